// File: hdl/gen1_compat_lane_tx.sv
// Per-port PHY control: compat training sets, lane transmit settings.
// Assumes an AXI4-Lite master on aclk; the LTSSM retrains on each pulse.
//
// Summary of operation
// - Compat enable, then full retrain, enters mode
// - Compat mode zeroes TS symbol-four bits 2,6,7
// - Clear enable plus retrain restores 2.0 bits
// - Twelve quads; x4 port n uses quad n
// - x8 merged port uses even and odd quads
// - Lane drive-level code, ~40 mV steps
// - Four boost levels, reset to second level
// - Drive-level updates taken anytime, no retrain
// - Nominal de-emphasis -3.5 dB, -6 dB Gen2 only
// - Coarse/fine de-emphasis codes, changeable anytime
// - Per-lane slew codes, changeable anytime
// - Low swing applies to all port lanes
// - Low swing forces 0 dB de-emphasis
// - Non-normal margin overrides all port lanes
// - Mode change applies matching register set
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "lanetx_consts.svh"

module gen1_compat_lane_tx #(
    parameter int NUM_PORTS      = 12,
    parameter int LANES_PER_QUAD = 4
) (
    // Clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // AXI4-Lite write address
    input  wire logic [15:0]            s_axi_awaddr,
    input  wire logic [2:0]             s_axi_awprot,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [15:0]            s_axi_araddr,
    input  wire logic [2:0]             s_axi_arprot,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // LTSSM side
    input  wire logic [NUM_PORTS-1:0]   link_gen2,
    output logic      [NUM_PORTS-1:0]   full_link_retrain,
    // Training-set symbol four
    input  wire logic [NUM_PORTS*8-1:0] ts_sym4_in,
    input  wire logic [NUM_PORTS-1:0]   ts_sym4_valid,
    output logic      [NUM_PORTS*8-1:0] ts_sym4_out,
    output logic      [NUM_PORTS-1:0]   ts_sym4_out_valid,
    // SerDes lane transmitter settings
    output lanetx_pkg::lane_tx_t        lane_tx [NUM_PORTS*LANES_PER_QUAD]
);

    localparam int NUM_LANES = NUM_PORTS * LANES_PER_QUAD;
    localparam int NUM_SETS  = `LTX_NUM_MODES * NUM_LANES;

    // Register state
    lanetx_pkg::port_cfg_t port_cfg_ff   [NUM_PORTS];
    lanetx_pkg::lane_set_t lane_set_ff   [NUM_SETS];
    lanetx_pkg::lane_tx_t  lane_tx_ff    [NUM_LANES];
    logic [NUM_PORTS-1:0]  compat_active_ff;
    logic [NUM_PORTS-1:0]  retrain_ff;

    // Bus state
    lanetx_pkg::wr_state_t wr_state_ff;
    logic                  aw_held_ff;
    logic                  w_held_ff;
    logic [15:0]           awaddr_ff;
    logic [31:0]           wdata_ff;
    logic [3:0]            wstrb_ff;
    logic [1:0]            bresp_ff;
    logic                  rvalid_ff;
    logic [31:0]           rdata_ff;
    logic [1:0]            rresp_ff;

    // Per-quad selection
    lanetx_pkg::tx_mode_t  quad_mode   [NUM_PORTS];
    lanetx_pkg::deemph_t   quad_deemph [NUM_PORTS];
    lanetx_pkg::port_cfg_t quad_cfg    [NUM_PORTS];

    function automatic lanetx_pkg::dec_t decode_addr(input logic [15:0] a);
        lanetx_pkg::dec_t d;
        logic [3:0] wi;
        logic [2:0] mode;
        logic [5:0] lane;
        d.kind = lanetx_pkg::REG_NONE;
        d.idx  = 8'h00;
        wi     = a[5:2];
        mode   = a[10:8];
        lane   = a[7:2];
        if ((a & `LTX_BANK_MASK) == `LTX_PORT_CFG_BASE && 32'(wi) < NUM_PORTS) begin
            d.kind = lanetx_pkg::REG_PORT_CFG;
            d.idx  = {4'h0, wi};
        end else if ((a & `LTX_BANK_MASK) == `LTX_PORT_STS_BASE && 32'(wi) < NUM_PORTS) begin
            d.kind = lanetx_pkg::REG_PORT_STS;
            d.idx  = {4'h0, wi};
        end else if ((a & `LTX_LANE_MASK) == `LTX_LANE_BASE
                     && 32'(mode) < `LTX_NUM_MODES && 32'(lane) < NUM_LANES) begin
            d.kind = lanetx_pkg::REG_LANE;
            d.idx  = 8'(32'(mode) * NUM_LANES + 32'(lane));
        end
        return d;
    endfunction : decode_addr

    function automatic logic [31:0] merge_strb(input logic [31:0] old_w, new_w,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old_w;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge_strb

    function automatic lanetx_pkg::lane_set_t default_set(input int mode);
        lanetx_pkg::lane_set_t s;
        s.drive_level   = (mode >= int'(lanetx_pkg::MODE_LS_G1)) ? `LTX_DRV_LS_RST
                                                                  : `LTX_DRV_FS_RST;
        s.boost         = `LTX_BOOST_RST;
        s.deemph_coarse = `LTX_DEEMPH_RST;
        s.deemph_fine   = `LTX_DEEMPH_RST;
        s.slew_coarse   = `LTX_SLEW_RST;
        s.slew_fine     = `LTX_SLEW_RST;
        return s;
    endfunction : default_set

    function automatic logic [31:0] cfg_word(input lanetx_pkg::port_cfg_t c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`LTX_CFG_COMPAT_BIT]  = c.compat_en;
        w[`LTX_CFG_LOWSW_BIT]   = c.low_swing;
        w[`LTX_CFG_SDE_BIT]     = c.sel_3p5db;
        w[`LTX_CFG_TM_LSB +: 3] = c.margin;
        w[`LTX_CFG_MERGE_BIT]   = c.merge;
        return w;
    endfunction : cfg_word

    // Write path decode
    wire lanetx_pkg::dec_t wr_dec;
    wire logic             wr_go;
    wire logic [31:0]      wr_old;
    wire logic [31:0]      wr_new;
    wire logic             retrain_req;

    assign wr_dec = decode_addr(awaddr_ff);
    assign wr_go  = (wr_state_ff == lanetx_pkg::WR_IDLE) && aw_held_ff && w_held_ff;
    assign wr_old = (wr_dec.kind == lanetx_pkg::REG_LANE)
                  ? {15'h0000, lane_set_ff[wr_dec.idx]}
                  : cfg_word(port_cfg_ff[wr_dec.idx[3:0]]);
    assign wr_new = merge_strb(wr_old, wdata_ff, wstrb_ff);
    assign retrain_req = wr_go && (wr_dec.kind == lanetx_pkg::REG_PORT_CFG)
                       && wstrb_ff[0] && wdata_ff[`LTX_CFG_RETRAIN_BIT];

    assign s_axi_awready = (wr_state_ff == lanetx_pkg::WR_IDLE) && !aw_held_ff;
    assign s_axi_wready  = (wr_state_ff == lanetx_pkg::WR_IDLE) && !w_held_ff;
    assign s_axi_bvalid  = (wr_state_ff == lanetx_pkg::WR_RESP);
    assign s_axi_bresp   = bresp_ff;

    // Read path decode
    wire lanetx_pkg::dec_t rd_dec;
    wire logic [31:0]      rd_word;
    wire logic [3:0]       rd_port;

    assign rd_dec  = decode_addr(s_axi_araddr);
    assign rd_port = rd_dec.idx[3:0];
    assign rd_word = (rd_dec.kind == lanetx_pkg::REG_PORT_CFG) ? cfg_word(port_cfg_ff[rd_port])
                   : (rd_dec.kind == lanetx_pkg::REG_LANE) ? {15'h0000, lane_set_ff[rd_dec.idx]}
                   : (rd_dec.kind == lanetx_pkg::REG_PORT_STS)
                     ? ({31'h0, compat_active_ff[rd_port]} << `LTX_STS_COMPAT_BIT)
                       | ({31'h0, link_gen2[rd_port]} << `LTX_STS_GEN2_BIT)
                       | ({29'h0, quad_mode[rd_port]} << `LTX_STS_MODE_LSB)
                       | ({30'h0, quad_deemph[rd_port]} << `LTX_STS_DEEMPH_LSB)
                   : 32'h0000_0000;

    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    // Write capture; AW and W in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awaddr_ff  <= 16'h0000;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held_ff <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held_ff <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_ff <= lanetx_pkg::WR_IDLE;
            bresp_ff    <= `LTX_RESP_OKAY;
        end else begin
            case (wr_state_ff)
                lanetx_pkg::WR_IDLE: begin
                    if (wr_go) begin
                        wr_state_ff <= lanetx_pkg::WR_RESP;
                        bresp_ff    <= (wr_dec.kind == lanetx_pkg::REG_NONE)
                                     ? `LTX_RESP_SLVERR : `LTX_RESP_OKAY;
                    end
                end
                lanetx_pkg::WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_ff <= lanetx_pkg::WR_IDLE;
                    end
                end
                default: begin
                    wr_state_ff <= lanetx_pkg::WR_IDLE;
                end
            endcase
        end
    end

    // Port config; status bank ignores writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                port_cfg_ff[p] <= '{margin: `LTX_TM_NORMAL, merge: 1'b0, sel_3p5db: 1'b1,
                                    low_swing: 1'b0, compat_en: 1'b0};
            end
        end else if (wr_go && wr_dec.kind == lanetx_pkg::REG_PORT_CFG) begin
            port_cfg_ff[wr_dec.idx[3:0]] <= '{
                margin:    wr_new[`LTX_CFG_TM_LSB +: 3],
                merge:     wr_new[`LTX_CFG_MERGE_BIT],
                sel_3p5db: wr_new[`LTX_CFG_SDE_BIT],
                low_swing: wr_new[`LTX_CFG_LOWSW_BIT],
                compat_en: wr_new[`LTX_CFG_COMPAT_BIT]};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_SETS; i++) begin
                lane_set_ff[i] <= default_set(i / NUM_LANES);
            end
        end else if (wr_go && wr_dec.kind == lanetx_pkg::REG_LANE) begin
            lane_set_ff[wr_dec.idx] <= wr_new[16:0];
        end
    end

    // Compat latch takes the enable written with the retrain bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            retrain_ff       <= '0;
            compat_active_ff <= '0;
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                retrain_ff[p] <= retrain_req && (wr_dec.idx[3:0] == 4'(p));
                if (retrain_req && wr_dec.idx[3:0] == 4'(p)) begin
                    compat_active_ff[p] <= wr_new[`LTX_CFG_COMPAT_BIT];
                end
            end
        end
    end

    assign full_link_retrain = retrain_ff;

    // Read data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= `LTX_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_word;
            rresp_ff  <= (rd_dec.kind == lanetx_pkg::REG_NONE) ? `LTX_RESP_SLVERR : `LTX_RESP_OKAY;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    lane_tx_select #(
        .NUM_PORTS (NUM_PORTS)
    ) u_select (
        .port_cfg    (port_cfg_ff),
        .link_gen2   (link_gen2),
        .quad_mode   (quad_mode),
        .quad_deemph (quad_deemph),
        .quad_cfg    (quad_cfg)
    );

    ts_sym4_filter #(
        .NUM_PORTS (NUM_PORTS)
    ) u_filter (
        .aclk              (aclk),
        .aresetn           (aresetn),
        .compat_active     (compat_active_ff),
        .ts_sym4_in        (ts_sym4_in),
        .ts_sym4_valid     (ts_sym4_valid),
        .ts_sym4_out       (ts_sym4_out),
        .ts_sym4_out_valid (ts_sym4_out_valid)
    );

    // Lanes follow owning port's mode a cycle later
    genvar l;
    generate
        for (l = 0; l < NUM_LANES; l++) begin : g_lane
            localparam int QUAD = l / LANES_PER_QUAD;
            wire logic [7:0]       set_idx;
            wire lanetx_pkg::lane_tx_t nxt_lane_tx;

            assign set_idx = 8'(32'(quad_mode[QUAD]) * NUM_LANES + l);
            assign nxt_lane_tx.set            = lane_set_ff[set_idx];
            assign nxt_lane_tx.margin_override = (quad_cfg[QUAD].margin != `LTX_TM_NORMAL);
            assign nxt_lane_tx.margin          = quad_cfg[QUAD].margin;
            assign nxt_lane_tx.low_swing       = quad_cfg[QUAD].low_swing;
            assign nxt_lane_tx.nominal_deemph  = quad_deemph[QUAD];

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    lane_tx_ff[l] <= '{set: default_set(0), margin_override: 1'b0,
                                       margin: `LTX_TM_NORMAL, low_swing: 1'b0,
                                       nominal_deemph: lanetx_pkg::DEEMPH_3P5DB};
                end else begin
                    lane_tx_ff[l] <= nxt_lane_tx;
                end
            end

            assign lane_tx[l] = lane_tx_ff[l];
        end
    endgenerate

endmodule : gen1_compat_lane_tx

`default_nettype wire

// File: hdl/lane_tx_select.sv
// Quad-to-port mapping and per-quad mode.
// Combinational; the caller registers the results.
`timescale 1ns/1ps
`default_nettype none
`include "lanetx_consts.svh"

module lane_tx_select #(
    parameter int NUM_PORTS = 12
) (
    // Port configuration and current rate
    input  wire lanetx_pkg::port_cfg_t port_cfg [NUM_PORTS],
    input  wire logic [NUM_PORTS-1:0] link_gen2,
    // Per-quad results
    output lanetx_pkg::tx_mode_t  quad_mode   [NUM_PORTS],
    output lanetx_pkg::deemph_t   quad_deemph [NUM_PORTS],
    output lanetx_pkg::port_cfg_t quad_cfg    [NUM_PORTS]
);

    genvar q;
    generate
        for (q = 0; q < NUM_PORTS; q++) begin : g_quad
            localparam int EVEN = q - (q % 2);
            wire logic owner_is_even;
            wire logic gen2;
            wire lanetx_pkg::port_cfg_t cfg;

            assign owner_is_even = port_cfg[EVEN].merge;
            assign cfg  = owner_is_even ? port_cfg[EVEN] : port_cfg[q];
            assign gen2 = owner_is_even ? link_gen2[EVEN] : link_gen2[q];
            assign quad_cfg[q] = cfg;

            assign quad_mode[q] = cfg.low_swing
                                ? (gen2 ? lanetx_pkg::MODE_LS_G2 : lanetx_pkg::MODE_LS_G1)
                                : (!gen2 ? lanetx_pkg::MODE_FS3_G1
                                  : (cfg.sel_3p5db ? lanetx_pkg::MODE_FS3_G2
                                                   : lanetx_pkg::MODE_FS6_G2));

            // 6 dB only at 5 GT/s
            assign quad_deemph[q] = cfg.low_swing ? lanetx_pkg::DEEMPH_0DB
                                  : ((gen2 && !cfg.sel_3p5db) ? lanetx_pkg::DEEMPH_6DB
                                                              : lanetx_pkg::DEEMPH_3P5DB);
        end
    endgenerate

endmodule : lane_tx_select

`default_nettype wire

// File: hdl/lanetx_consts.svh
// Offsets, field positions, reset values and codes for the port PHY control block.
// Definitions only; included by package and design.
`ifndef LANETX_CONSTS_SVH
`define LANETX_CONSTS_SVH

// Register banks (byte addresses)
`define LTX_BANK_MASK       16'hFFC0
`define LTX_LANE_MASK       16'hF800
`define LTX_PORT_CFG_BASE   16'h0000
`define LTX_PORT_STS_BASE   16'h0040
`define LTX_LANE_BASE       16'h0800

// Port config bits
`define LTX_CFG_COMPAT_BIT  0
`define LTX_CFG_RETRAIN_BIT 1
`define LTX_CFG_LOWSW_BIT   2
`define LTX_CFG_SDE_BIT     3
`define LTX_CFG_TM_LSB      4
`define LTX_CFG_MERGE_BIT   7

// Port status bits
`define LTX_STS_COMPAT_BIT  0
`define LTX_STS_GEN2_BIT    1
`define LTX_STS_MODE_LSB    2
`define LTX_STS_DEEMPH_LSB  5

// Lane register sets, one per PHY mode
`define LTX_NUM_MODES       5

// Normal-range margin code
`define LTX_TM_NORMAL       3'h0

// Lane set reset values
`define LTX_DRV_FS_RST      5'h00
`define LTX_DRV_LS_RST      5'h0B
`define LTX_BOOST_RST       2'h1
`define LTX_DEEMPH_RST      3'h0
`define LTX_SLEW_RST        2'h0

// Symbol-four bits zeroed in compat mode
`define LTX_SYM4_COMPAT_MASK 8'hC4

// AXI responses
`define LTX_RESP_OKAY       2'h0
`define LTX_RESP_SLVERR     2'h2

`endif

// File: hdl/lanetx_pkg.sv
// Types of the port PHY control block.
// Assumes lanetx_consts.svh is on the include path.
`include "lanetx_consts.svh"

package lanetx_pkg;

    typedef enum logic [2:0] {
        MODE_FS3_G1 = 3'h0,
        MODE_FS3_G2 = 3'h1,
        MODE_FS6_G2 = 3'h2,
        MODE_LS_G1  = 3'h3,
        MODE_LS_G2  = 3'h4
    } tx_mode_t;

    typedef enum logic [1:0] {
        DEEMPH_0DB   = 2'h0,
        DEEMPH_3P5DB = 2'h1,
        DEEMPH_6DB   = 2'h2
    } deemph_t;

    typedef struct packed {
        logic [2:0] margin;
        logic       merge;
        logic       sel_3p5db;
        logic       low_swing;
        logic       compat_en;
    } port_cfg_t;

    typedef struct packed {
        logic [1:0] slew_fine;
        logic [1:0] slew_coarse;
        logic [2:0] deemph_fine;
        logic [2:0] deemph_coarse;
        logic [1:0] boost;
        logic [4:0] drive_level;
    } lane_set_t;

    typedef struct packed {
        lane_set_t  set;
        logic       margin_override;
        logic [2:0] margin;
        logic       low_swing;
        deemph_t    nominal_deemph;
    } lane_tx_t;

    typedef enum logic [1:0] {
        REG_NONE     = 2'h0,
        REG_PORT_CFG = 2'h1,
        REG_PORT_STS = 2'h2,
        REG_LANE     = 2'h3
    } reg_kind_t;

    typedef struct packed {
        reg_kind_t  kind;
        logic [7:0] idx;
    } dec_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } wr_state_t;

endpackage : lanetx_pkg

// File: hdl/ts_sym4_filter.sv
// Symbol-four filter for transmitted training sets.
// Assumes ts_sym4_valid marks symbol four of each TS.
`timescale 1ns/1ps
`default_nettype none
`include "lanetx_consts.svh"

module ts_sym4_filter #(
    parameter int NUM_PORTS = 12
) (
    // Clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // Latched compatibility state per port
    input  wire logic [NUM_PORTS-1:0]   compat_active,
    // Symbol four from the training-set generator
    input  wire logic [NUM_PORTS*8-1:0] ts_sym4_in,
    input  wire logic [NUM_PORTS-1:0]   ts_sym4_valid,
    // Symbol four toward the serializer
    output logic      [NUM_PORTS*8-1:0] ts_sym4_out,
    output logic      [NUM_PORTS-1:0]   ts_sym4_out_valid
);

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            wire logic [7:0] sym4_masked;
            assign sym4_masked = compat_active[p]
                               ? (ts_sym4_in[p*8 +: 8] & ~`LTX_SYM4_COMPAT_MASK)
                               : ts_sym4_in[p*8 +: 8];

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    ts_sym4_out[p*8 +: 8] <= 8'h00;
                    ts_sym4_out_valid[p]  <= 1'b0;
                end else begin
                    ts_sym4_out[p*8 +: 8] <= sym4_masked;
                    ts_sym4_out_valid[p]  <= ts_sym4_valid[p];
                end
            end
        end
    endgenerate

endmodule : ts_sym4_filter

`default_nettype wire

// File: sim/gen1_compat_lane_tx_sva.sv
// Checker on the block's top ports.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
module gen1_compat_lane_tx_sva #(
    parameter int NUM_PORTS      = 12,
    parameter int LANES_PER_QUAD = 4
) (
    // Clock, reset, bus
    input wire logic                   aclk,
    input wire logic                   aresetn,
    input wire logic                   s_axi_awready,
    input wire logic                   s_axi_bvalid,
    input wire logic                   s_axi_arready,
    input wire logic                   s_axi_rvalid,
    // Link side
    input wire logic [NUM_PORTS-1:0]   link_gen2,
    input wire logic [NUM_PORTS-1:0]   full_link_retrain,
    input wire logic [NUM_PORTS*8-1:0] ts_sym4_in,
    input wire logic [NUM_PORTS-1:0]   ts_sym4_valid,
    input wire logic [NUM_PORTS*8-1:0] ts_sym4_out,
    input wire logic [NUM_PORTS-1:0]   ts_sym4_out_valid,
    input var lanetx_pkg::lane_tx_t    lane_tx [NUM_PORTS*LANES_PER_QUAD]
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ts_lat_a: assert property (ts_sym4_out_valid == $past(ts_sym4_valid))
        else $error("ts latency");
    ts_pass_a: assert property (ts_sym4_out_valid[0] |->
        ((ts_sym4_out[7:0] ^ $past(ts_sym4_in[7:0])) & 8'h3B) == 8'h00) else $error("ts bits lost");
    pulse_one_a: assert property (|full_link_retrain |=> !(|full_link_retrain))
        else $error("long retrain");
    pulse_resp_a: assert property (|full_link_retrain |-> $rose(s_axi_bvalid))
        else $error("retrain late");
    aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw taken");
    ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken");
    ls_deemph_a: assert property (lane_tx[0].low_swing |->
        lane_tx[0].nominal_deemph == lanetx_pkg::DEEMPH_0DB) else $error("low swing deemph");
    quad_same_a: assert property ({lane_tx[0].low_swing, lane_tx[0].margin} ==
        {lane_tx[3].low_swing, lane_tx[3].margin}) else $error("lanes differ");
    margin_ovr_a: assert property (lane_tx[0].margin_override == (lane_tx[0].margin != 3'h0))
        else $error("margin ovr");
    g1_deemph_a: assert property (lane_tx[0].nominal_deemph == lanetx_pkg::DEEMPH_6DB |->
        $past(link_gen2[0])) else $error("6 dB at low rate");
    cover property (|full_link_retrain);
    cover property (lane_tx[0].low_swing);
    cover property (lane_tx[0].margin_override);
endmodule : gen1_compat_lane_tx_sva
bind gen1_compat_lane_tx gen1_compat_lane_tx_sva #(.NUM_PORTS(NUM_PORTS),
    .LANES_PER_QUAD(LANES_PER_QUAD)) gen1_compat_lane_tx_sva_i (.*);
`default_nettype wire

// File: sim/ltssm_model.sv
// LTSSM model: link rate and TS symbol four per port.
// Rate changes come from gen2_req.
`timescale 1ns/1ps
`default_nettype none
module ltssm_model (
    // Clock, reset and rate request
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] gen2_req,
    // From the block
    input  wire logic [11:0] full_link_retrain,
    // Toward the block
    output logic      [11:0] link_gen2,
    output logic      [95:0] ts_sym4_in,
    output logic      [11:0] ts_sym4_valid
);
    int seed = 32'h1D5;
    always_ff @(posedge aclk) begin
        link_gen2     <= aresetn ? gen2_req : 12'h000;
        ts_sym4_valid <= aresetn ? 12'($random(seed)) & ~full_link_retrain : 12'h000;
        ts_sym4_in    <= {3{$random(seed)}};
    end
endmodule : ltssm_model
`default_nettype wire

// File: sim/tb_top.sv
// Bench: random and corner bus traffic.
// Assumes the LTSSM model and bound checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
    $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic s_axi_bready = 1, s_axi_rready = 1, cmp = 0, wcmp = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
    logic [3:0]  s_axi_wstrb = 4'hF, v;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [11:0] link_gen2, full_link_retrain, ts_sym4_valid, ts_sym4_out_valid, gen2_req = 0;
    logic [95:0] ts_sym4_in, ts_sym4_out;
    logic [16:0] x, ms [5];
    logic [7:0]  exp_ts, cv [4] = '{8'h09, 8'h0B, 8'h09, 8'h0A};
    logic [8:0]  tbl [5] = '{9'h108, 9'h100, 9'h000, 9'h004, 9'h10C};
    logic [4:0]  e;
    lanetx_pkg::lane_tx_t lane_tx [48];
    int failures = 0, checks_done = 0, seed = 32'h83A8, l;
    gen1_compat_lane_tx gen1_compat_lane_tx_i (.*);
    ltssm_model ltssm_model_i (.*);
    initial forever #12.5 aclk = ~aclk;
    function automatic logic [4:0] mode_of(input logic g, input logic [7:0] c);
        return {c[2] ? 2'h0 : (g && !c[3] ? 2'h2 : 2'h1),
                c[2] ? (g ? 3'h4 : 3'h3) : (g ? (c[3] ? 3'h1 : 3'h2) : 3'h0)};
    endfunction : mode_of
    always @(posedge aclk) begin
        if (full_link_retrain[0])
            cmp <= wcmp;
        exp_ts <= ts_sym4_in[7:0] & ((full_link_retrain[0] ? wcmp : cmp) ? 8'h3B : 8'hFF);
    end
    always @(negedge aclk) if (aresetn && ts_sym4_out_valid[0]) `CHK(ts_sym4_out[7:0], exp_ts)
    task automatic stop_test(input logic hung);
        failures += hung;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    task automatic bus(input logic we, input logic [15:0] a, input logic [31:0] w, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= w;
        s_axi_awvalid <= we;
        s_axi_wvalid <= we;
        s_axi_arvalid <= !we;
        if (we && a == 16'h0000)
            wcmp = w[0];
        for (int n = 0; n <= 40; n++) begin
            if (n == 40)
                stop_test(1);
            @(negedge aclk);
            v = {s_axi_awready, s_axi_wready, s_axi_arready, we ? s_axi_bvalid : s_axi_rvalid};
            r = we ? s_axi_bresp : s_axi_rresp;
            d = s_axi_rdata;
            @(posedge aclk);
            if (v[0])
                break;
            if (v[3])
                s_axi_awvalid <= 0;
            if (v[2])
                s_axi_wvalid <= 0;
            if (v[1])
                s_axi_arvalid <= 0;
        end
        `CHK(r, er)
    endtask : bus
    task automatic settle;
        repeat (3) @(negedge aclk);
    endtask : settle
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        settle();
        for (int i = 0; i < 48; i++) `CHK({lane_tx[i].set, lane_tx[i].nominal_deemph}, 19'h81)
        for (int k = 0; k < 6; k++) begin
            l = k == 0 ? 47 : {$random(seed)} % 48;
            x = 17'($random(seed));
            bus(1, 16'h0800 + 16'(l * 4), 32'(x), 2'h0);
            settle();
            `CHK(lane_tx[l].set, x)
            bus(0, 16'h0800 + 16'(l * 4), 32'h0, 2'h0);
            `CHK(d[16:0], x)
        end
        for (int m = 0; m < 5; m++) begin
            ms[m] = 17'($random(seed));
            bus(1, 16'h0804 + 16'(m * 256), 32'(ms[m]), 2'h0);
        end
        foreach (tbl[i]) begin
            bus(1, 16'h0000, 32'(tbl[i][7:0]), 2'h0);
            gen2_req <= {12{tbl[i][8]}};
            settle();
            e = mode_of(tbl[i][8], tbl[i][7:0]);
            `CHK(lane_tx[1].set, ms[e[2:0]])
            `CHK({lane_tx[3].low_swing, lane_tx[1].nominal_deemph}, {tbl[i][2], e[4:3]})
            bus(0, 16'h0040, 32'h0, 2'h0);
            `CHK(d[6:2], e)
        end
        bus(1, 16'h0000, 32'hBC, 2'h0);
        settle();
        `CHK({lane_tx[7].margin_override, lane_tx[7].margin, lane_tx[7].low_swing}, 5'h17)
        `CHK({lane_tx[8].margin_override, lane_tx[8].low_swing}, 2'h0)
        foreach (cv[i]) begin
            bus(1, 16'h0000, 32'(cv[i]), 2'h0);
            repeat (20) @(posedge aclk);
            bus(0, 16'h0040, 32'h0, 2'h0);
            `CHK(d[0], cmp)
        end
        bus(0, 16'h0400, 32'h0, 2'h2);
        bus(1, 16'h0400, 32'hFFFFFFFF, 2'h2);
        stop_test(0);
    end
endmodule : tb_top
`default_nettype wire
